// *** hw/cftr_recorder.v ***
// trace recorder: event encoder, entry fifo, byte memory
// assumes core events on core_clk and one event per cycle
`timescale 1ns/100ps
`default_nettype none
`include "cftr_regs.vh"

// ****************************************
// entry fifo
// ****************************************
// keeps whole entries so a five-byte entry is never split
module cftr_fifo #(
    parameter WIDTH = 41,
    parameter DEPTH = 16
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    // pointer width follows the depth; depth is a power of two
    localparam AW = $clog2(DEPTH);

    reg [WIDTH-1:0] store [0:DEPTH-1]; // entry storage
    reg [AW-1:0] headReg; // next to read
    reg [AW-1:0] tailReg; // next to write
    reg [AW:0] fillReg; // entries held

    // a push and a pop may share one edge
    wire doPush;
    wire doPop;

    // honest full and empty from the fill count
    assign inReady = (fillReg != DEPTH[AW:0]);
    assign outValid = (fillReg != {(AW+1){1'b0}});
    assign outData = store[headReg];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // storage write, no reset needed on data
    // limitation: outData is unknown while the fifo is empty
    always @(posedge core_clk) begin
        if (doPush) begin
            store[tailReg] <= inData;
        end
    end

    // pointers and count
    // count is one wider than the pointers so full and empty differ
    always @(posedge core_clk) begin
        if (reset) begin
            headReg <= {AW{1'b0}};
            tailReg <= {AW{1'b0}};
            fillReg <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                tailReg <= tailReg + 1'b1;
            end
            if (doPop) begin
                headReg <= headReg + 1'b1;
            end
            if (doPush && !doPop) begin
                fillReg <= fillReg + 1'b1;
            end else if (doPop && !doPush) begin
                fillReg <= fillReg - 1'b1;
            end
        end
    end
endmodule

// ****************************************
// trace recorder top
// ****************************************
// limitation: software must stop capture and let the fifo drain
// before reading, or reads and drained bytes interleave
module cftr_recorder (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // control from debug logic
    input wire traceStart,
    input wire traceStop,
    input wire wrapMode,
    input wire cpuReset,
    // retirement events from the core
    input wire retireValid,
    input wire branchValid,
    input wire branchIndirect,
    input wire branchCheckpoint,
    input wire [31:0] branchTarget,
    input wire exceptionValid,
    input wire [4:0] exceptionOffset,
    input wire debugException,
    input wire debugReturn,
    input wire [31:0] debugTarget,
    output wire coreStall,
    // trace read port
    input wire readReq,
    output reg [31:0] readData,
    output reg readValid,
    // status
    output reg traceActive,
    output reg bufferFull,
    output reg fullTrap
);
    // ****************************************
    // state
    // ****************************************
    // circular memory; ptrReg is both the write point and the oldest byte
    // no reset on the bytes, so a core reset leaves the trace readable
    reg [7:0] traceMem [0:255]; // trace bytes
    reg [`CFTR_PTR_W-1:0] ptrReg; // next write, also oldest
    reg [8:0] reservedReg; // bytes claimed since start
    reg [3:0] countReg; // incremental count
    reg [2:0] drainIdxReg; // byte within entry

    // ****************************************
    // event encoding
    // ****************************************
    wire [`CFTR_ENTRY_W-1:0] entryData;
    wire [`CFTR_ENTRY_W-1:0] fifoOut;
    wire fifoInReady;
    wire fifoOutValid;
    wire fifoOutReady;
    reg needEntry; // event makes a message
    reg [7:0] msgByte; // message to store
    reg isIndirect; // entry carries address
    reg [31:0] tgtAddr; // address bytes
    reg clearCount; // counter restarts
    reg bumpCount; // counter increments
    wire [8:0] entryLen;
    wire fits;
    wire pushValid;
    wire eventTaken;
    wire anyEvent;

    // capture only while enabled and core not in reset
    wire capturing = traceActive && !cpuReset;

    // pick the message for this cycle's event
    always @* begin
        // defaults: no entry, counter left alone
        needEntry = 1'b0;
        msgByte = 8'h00;
        isIndirect = 1'b0;
        tgtAddr = 32'h0000_0000;
        clearCount = 1'b0;
        bumpCount = 1'b0;
        if (debugException) begin
            // debug entry leaves no trace
            needEntry = 1'b0;
        end else if (exceptionValid) begin
            // type bit zero, vector bits, count so far
            needEntry = 1'b1;
            msgByte = {1'b0, exceptionOffset[4:2], countReg};
            clearCount = 1'b1;
        end else if (debugReturn) begin
            // return to application as indirect
            needEntry = 1'b1;
            msgByte = {`CFTR_MSG_IND_TYPE, countReg};
            isIndirect = 1'b1;
            tgtAddr = debugTarget;
            clearCount = 1'b1;
        end else if (branchValid) begin
            // branch excluded from its own count
            needEntry = 1'b1;
            msgByte[`CFTR_MSG_BRANCH_BIT] = 1'b1;
            msgByte[`CFTR_MSG_CKPT_BIT] = branchCheckpoint;
            msgByte[`CFTR_MSG_IND_BIT] = branchIndirect;
            msgByte[3:0] = countReg;
            isIndirect = branchIndirect;
            tgtAddr = branchTarget;
            clearCount = 1'b1;
        end else if (retireValid) begin
            // sixteenth plain instruction rolls over
            if (countReg == `CFTR_CNT_MAX) begin
                needEntry = 1'b1;
                msgByte = `CFTR_MSG_ROLLOVER;
                clearCount = 1'b1;
            end else begin
                bumpCount = 1'b1;
            end
        end
    end

    // entry length and fill-once room check
    assign entryLen = isIndirect ? `CFTR_LEN_FIVE : `CFTR_LEN_ONE;
    // tally counts bytes since start, so a pointer wrap is no hazard
    assign fits = wrapMode ||
        ((reservedReg + entryLen) <= `CFTR_BUF_BYTES);
    // fifo word: address flag, target, message byte
    assign entryData = {isIndirect, tgtAddr, msgByte};
    // every event handed over, including those that leave no entry
    assign anyEvent = debugException || exceptionValid || debugReturn ||
        branchValid || retireValid;
    // an entry that does not fit never enters the fifo
    assign pushValid = capturing && needEntry && fits;

    // hold the core while an entry meets a fifo with no room
    // a stalled event is neither counted nor stored; the core retries it
    assign coreStall = pushValid && !fifoInReady;
    assign eventTaken = capturing && anyEvent && !coreStall;

    // ****************************************
    // counter and enable
    // ****************************************
    // counter follows taken events only
    // start clears it so the first message counts from the enable
    always @(posedge core_clk) begin
        if (reset) begin
            countReg <= 4'h0;
        end else if (traceStart) begin
            countReg <= 4'h0;
        end else if (eventTaken) begin
            if (clearCount) begin
                countReg <= 4'h0;
            end else if (bumpCount) begin
                countReg <= countReg + 4'h1;
            end
        end
    end

    // enable, fill-once stop and trap pulse
    // a start in the cycle of a full hit re-arms the tally, so the
    // dropped entry is the only loss and no trap is raised for it
    always @(posedge core_clk) begin
        if (reset) begin
            traceActive <= 1'b0;
            bufferFull <= 1'b0;
            fullTrap <= 1'b0;
            reservedReg <= 9'h000;
        end else begin
            fullTrap <= 1'b0;
            if (cpuReset || traceStop) begin
                // contents kept, capture halted
                traceActive <= 1'b0;
            end else if (traceStart) begin
                traceActive <= 1'b1;
                bufferFull <= 1'b0;
                reservedReg <= 9'h000;
            end else if (capturing && needEntry && !fits) begin
                // full: stop and raise debug trap
                traceActive <= 1'b0;
                bufferFull <= 1'b1;
                fullTrap <= 1'b1;
            end else if (pushValid && fifoInReady && !wrapMode) begin
                reservedReg <= reservedReg + entryLen;
            end
        end
    end

    // ****************************************
    // entry fifo
    // ****************************************
    // sixteen whole entries absorb bursts of five-byte entries
    cftr_fifo #(
        .WIDTH(`CFTR_ENTRY_W),
        .DEPTH(`CFTR_FIFO_DEPTH)
    ) cftr_fifo_inst (
        .core_clk(core_clk),
        .reset(reset),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(entryData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    // ****************************************
    // drain into byte memory
    // ****************************************
    // split head entry address into bytes, most significant first
    wire [7:0] addrByte [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : byteSel
            assign addrByte[g] = fifoOut[8*(4-g)+7:8*(4-g)];
        end
    endgenerate

    // head entry decode; one-byte entries finish in one cycle
    wire headInd = fifoOut[`CFTR_ENTRY_IND_BIT];
    // reads take the memory port, so the drain waits a cycle
    wire drainGo = fifoOutValid && !readReq; // reads win the port
    // five-byte entries end at index four with the message byte
    wire lastByte = !headInd || (drainIdxReg == `CFTR_LAST_IDX);
    wire [7:0] drainByte = lastByte ? fifoOut[7:0] :
        addrByte[drainIdxReg[1:0]];

    // message byte goes last so newest byte is a message
    assign fifoOutReady = drainGo && lastByte;

    // one write per cycle: read-clear or drain byte
    // no reset here: a core reset must leave the trace in place
    always @(posedge core_clk) begin
        if (readReq) begin
            traceMem[ptrReg] <= 8'h00;
        end else if (drainGo) begin
            traceMem[ptrReg] <= drainByte;
        end
    end

    // pointer walks forward; oldest byte sits at it
    // 256 reads bring it back to where the readout began
    always @(posedge core_clk) begin
        if (reset) begin
            ptrReg <= {`CFTR_PTR_W{1'b0}};
            drainIdxReg <= 3'h0;
        end else if (readReq) begin
            ptrReg <= ptrReg + 1'b1;
        end else if (drainGo) begin
            ptrReg <= ptrReg + 1'b1;
            drainIdxReg <= lastByte ? 3'h0 : drainIdxReg + 3'h1;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // oldest byte in low lane, upper lanes zero
    // the clear lands after this read, so the old byte comes out
    // readValid answers each request for exactly one cycle
    always @(posedge core_clk) begin
        if (reset) begin
            readData <= 32'h0000_0000;
            readValid <= 1'b0;
        end else begin
            readValid <= readReq;
            if (readReq) begin
                readData <= {24'h00_0000, traceMem[ptrReg]};
            end
        end
    end
endmodule

`default_nettype wire

// *** hw/cftr_regs.vh ***
// constants for the control-flow trace recorder
// assumes core_clk at 200 MHz and no register bus
// What this block does
// - entries are one message byte or five bytes
// - exception writes one byte, top bit zero
// - vector field carries vector offset bits 4:2
// - exception count excludes faulting instruction
// - skipped conditionals count; back-to-back gives zero
// - direct branch type 1000, checkpointed 1100
// - indirect type 1001/1101 plus four address bytes
// - core classifies branches direct or indirect
// - count excludes branch; rollover after count 15
// - rollover byte is all ones, sixteen instructions
// - sixteenth instruction branch replaces the rollover
// - address read most significant byte first
// - 256 bytes, read oldest first, newest last
// - newest byte is always a message byte
// - each read clears that byte to zero
// - processor reset disables tracing, keeps contents
// - no entry for reset or debug exception
// - debug return recorded as indirect entry
// - only branches checkpointed, bit six set
// - fill-once stops and traps; wrap overwrites
// - read returns oldest byte in low byte
`ifndef CFTR_REGS_VH
`define CFTR_REGS_VH

// ****************************************
// buffer geometry
// ****************************************
`define CFTR_BUF_BYTES 9'h100
`define CFTR_PTR_W 8
`define CFTR_FIFO_DEPTH 16
`define CFTR_ENTRY_W 41

// ****************************************
// message byte fields
// ****************************************
`define CFTR_MSG_BRANCH_BIT 7
`define CFTR_MSG_CKPT_BIT 6
`define CFTR_MSG_IND_BIT 4
`define CFTR_MSG_ROLLOVER 8'hff
`define CFTR_CNT_MAX 4'hf
`define CFTR_ENTRY_IND_BIT 40
`define CFTR_MSG_IND_TYPE 4'h9
`define CFTR_LEN_ONE 9'h001
`define CFTR_LEN_FIVE 9'h005
`define CFTR_LAST_IDX 3'h4

`endif

// *** tb/cftr_recorder_chk.sv ***
// port checker for the trace recorder
// assumes a bind onto cftr_recorder, one clock domain
`timescale 1ns/100ps
`default_nettype none
module cftr_recorder_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control
    input wire logic traceStart,
    input wire logic traceStop,
    input wire logic wrapMode,
    input wire logic cpuReset,
    // read port and status
    input wire logic readReq,
    input wire logic [31:0] readData,
    input wire logic readValid,
    input wire logic traceActive,
    input wire logic bufferFull,
    input wire logic fullTrap
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_readAnswer; readReq |=> readValid; endproperty
    property p_readCause; readValid |-> $past(readReq); endproperty
    property p_lowByte; readValid |-> readData[31:8] == 24'h0; endproperty
    property p_cpuOff; cpuReset |=> !traceActive; endproperty
    property p_startOn; traceStart && !traceStop && !cpuReset |=> traceActive && !bufferFull; endproperty
    property p_stopOff; traceStop && !traceStart |=> !traceActive; endproperty
    property p_trapPulse; fullTrap |=> !fullTrap; endproperty
    property p_trapFull; fullTrap |-> bufferFull && !traceActive; endproperty
    property p_wrapNoFull; $rose(bufferFull) |-> !$past(wrapMode); endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
    a_readCause: assert property (p_readCause) else $error("answer without read");
    a_lowByte: assert property (p_lowByte) else $error("upper read bytes set");
    a_cpuOff: assert property (p_cpuOff) else $error("capture on in cpu reset");
    a_startOn: assert property (p_startOn) else $error("start not taken");
    a_stopOff: assert property (p_stopOff) else $error("stop not taken");
    a_trapPulse: assert property (p_trapPulse) else $error("trap too long");
    a_trapFull: assert property (p_trapFull) else $error("trap while not full");
    a_wrapNoFull: assert property (p_wrapNoFull) else $error("full in wrap mode");
    c_trap: cover property (fullTrap);
    c_read: cover property (readValid);
    c_cpuReset: cover property (cpuReset && traceActive);
endmodule
bind cftr_recorder cftr_recorder_chk cftr_recorder_chk_inst (.core_clk(core_clk), .reset(reset),
    .traceStart(traceStart), .traceStop(traceStop), .wrapMode(wrapMode), .cpuReset(cpuReset),
    .readReq(readReq), .readData(readData), .readValid(readValid), .traceActive(traceActive),
    .bufferFull(bufferFull), .fullTrap(fullTrap));
`default_nettype wire

// *** tb/cftr_host_model.sv ***
// debug software model: reads the whole trace memory
// assumes the answer arrives one edge after the read
`timescale 1ns/100ps
`default_nettype none
module cftr_host_model (
    // clock
    input wire logic core_clk,
    // trace read port
    output logic readReq,
    input wire logic [31:0] readData,
    input wire logic readValid
);
    logic [31:0] rdBuf [0:255]; // last readout, oldest first
    int rdMiss = 0; // reads with no answer
    initial readReq = 1'b0;
    // all 256 bytes, since a partial readout leaves stale bytes behind
    task automatic readAll();
        for (int i = 0; i < 256; i++) begin
            @(negedge core_clk) readReq = 1'b1;
            @(negedge core_clk) readReq = 1'b0;
            if (readValid !== 1'b1) rdMiss++;
            rdBuf[i] = readData;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/cftr_recorder_test.sv ***
// self-checking bench for the trace recorder
// assumes the host model reads and the bench plays the core
`timescale 1ns/100ps
`default_nettype none
module cftr_recorder_test;
    logic core_clk = 0, reset = 1, traceStart = 0, traceStop = 0, wrapMode = 1, cpuReset = 0;
    logic retireValid = 0, branchValid = 0, branchIndirect = 0, branchCheckpoint = 0;
    logic exceptionValid = 0, debugException = 0, debugReturn = 0;
    logic [31:0] branchTarget = 0, debugTarget = 0;
    logic [4:0] exceptionOffset = 0;
    wire coreStall, readReq, readValid, traceActive, bufferFull, fullTrap;
    wire [31:0] readData;
    logic [7:0] expQ [$]; // bytes expected at the newest end
    int n_mismatch = 0, tests_run = 0, nTrap = 0, cycles = 0, nStall = 0;
    always #2.5 core_clk = ~core_clk;
    cftr_recorder cftr_recorder_inst (.core_clk(core_clk), .reset(reset), .traceStart(traceStart),
        .traceStop(traceStop), .wrapMode(wrapMode), .cpuReset(cpuReset), .retireValid(retireValid),
        .branchValid(branchValid), .branchIndirect(branchIndirect), .branchCheckpoint(branchCheckpoint),
        .branchTarget(branchTarget), .exceptionValid(exceptionValid), .exceptionOffset(exceptionOffset),
        .debugException(debugException), .debugReturn(debugReturn), .debugTarget(debugTarget),
        .coreStall(coreStall), .readReq(readReq), .readData(readData), .readValid(readValid),
        .traceActive(traceActive), .bufferFull(bufferFull), .fullTrap(fullTrap));
    cftr_host_model cftr_host_model_inst (.core_clk(core_clk), .readReq(readReq), .readData(readData),
        .readValid(readValid));
    // trap pulses, stall cycles and hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (fullTrap === 1'b1) nTrap++;
        if (coreStall === 1'b1) nStall++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask
    // core event: 0 retire, 1 branch, 2 exception, 3 debug trap, 4 debug return, 7 idle
    task automatic ev(input logic [2:0] k, input logic ind, input logic ck, input logic [31:0] t);
        @(negedge core_clk);
        {retireValid, branchValid, exceptionValid} = {k == 3'h0, k == 3'h1, k == 3'h2};
        {debugException, debugReturn, branchIndirect, branchCheckpoint} = {k == 3'h3, k == 3'h4, ind, ck};
        {branchTarget, debugTarget, exceptionOffset} = {t, t, t[4:0]};
        // core holds the event while the entry fifo refuses it;
        // the stall is combinational, so let it settle before looking
        #1;
        for (int w = 0; w < 40 && coreStall === 1'b1; w++) @(negedge core_clk);
    endtask
    task automatic rep(input int n, input logic [2:0] k);
        for (int i = 0; i < n; i++) ev(k, 1'b0, 1'b0, 32'h0);
    endtask
    task automatic ctl(input logic [1:0] m);
        @(negedge core_clk) {traceStop, traceStart} = m;
        @(negedge core_clk) {traceStop, traceStart} = 2'h0;
    endtask
    // stop, drain, read all, compare with zeros then expQ
    task automatic readCheck();
        int z;
        ctl(2'h2);
        // sixteen queued five-byte entries take 80 cycles to drain
        repeat (100) @(negedge core_clk);
        cftr_host_model_inst.readAll();
        z = 256 - expQ.size();
        for (int i = 0; i < 256; i++)
            chk("trace byte", {24'h0, i < z ? 8'h00 : expQ[i - z]}, cftr_host_model_inst.rdBuf[i]);
        expQ.delete();
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        cftr_host_model_inst.readAll();
        readCheck();
        ctl(2'h1);
        rep(3, 3'h0);
        ev(3'h1, 1'b0, 1'b0, 32'h0);
        ev(3'h1, 1'b0, 1'b1, 32'h0);
        rep(2, 3'h0);
        ev(3'h2, 1'b0, 1'b0, 32'h14);
        ev(3'h3, 1'b0, 1'b0, 32'h0);
        ev(3'h1, 1'b1, 1'b1, 32'h12345678);
        rep(16, 3'h0);
        rep(15, 3'h0);
        ev(3'h1, 1'b0, 1'b0, 32'h0);
        rep(1, 3'h0);
        ev(3'h4, 1'b0, 1'b0, 32'hcafe0004);
        expQ = '{8'h83, 8'hc0, 8'h52, 8'h12, 8'h34, 8'h56, 8'h78, 8'hd0, 8'hff, 8'h8f,
            8'hca, 8'hfe, 8'h00, 8'h04, 8'h91};
        rep(1, 3'h7);
        ctl(2'h2);
        // branches would leave entries if capture were still on
        rep(2, 3'h1);
        rep(1, 3'h7);
        readCheck();
        ctl(2'h1);
        rep(1, 3'h1);
        rep(1, 3'h7);
        @(negedge core_clk) cpuReset = 1'b1;
        rep(2, 3'h1);
        rep(1, 3'h7);
        chk("traceActive", 32'h0, {31'h0, traceActive});
        @(negedge core_clk) cpuReset = 1'b0;
        expQ = '{8'h80};
        readCheck();
        @(negedge core_clk) wrapMode = 1'b0;
        ctl(2'h1);
        rep(257, 3'h1);
        rep(3, 3'h7);
        chk("fill-once end", 32'h3, {30'h0, bufferFull, !traceActive});
        chk("trap count", 32'h1, nTrap);
        for (int i = 0; i < 256; i++) expQ.push_back(8'h80);
        readCheck();
        @(negedge core_clk) wrapMode = 1'b1;
        ctl(2'h1);
        ev(3'h2, 1'b0, 1'b0, 32'h08);
        rep(256, 3'h1);
        rep(3, 3'h7);
        chk("wrap end", 32'h1, {30'h0, bufferFull, traceActive});
        for (int i = 0; i < 256; i++) expQ.push_back(8'h80);
        readCheck();
        // indirect bursts outrun the drain, so the fifo fills and stalls the core
        ctl(2'h1);
        for (int i = 0; i < 30; i++) ev(3'h1, 1'b1, 1'b0, 32'h89abcdef);
        rep(1, 3'h7);
        chk("stall seen", 32'h1, {31'h0, nStall > 0});
        for (int i = 0; i < 30; i++) expQ = {expQ, 8'h89, 8'hab, 8'hcd, 8'hef, 8'h90};
        readCheck();
        chk("trap count", 32'h1, nTrap);
        chk("read answers missed", 32'h0, cftr_host_model_inst.rdMiss);
        print_verdict();
    end
endmodule
`default_nettype wire
